// file: bench/converter_fault_supervisor_checker.sv
module converter_fault_supervisor_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_enable,
  input wire logic [11:0] i_vin,
  input wire logic [11:0] i_output_sense_input,
  input wire logic        i_ext_clk_mode,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_high_drive_en,
  input wire logic        o_low_drive_en,
  input wire logic        o_power_good_output,
  input wire logic        o_input_low_lockout
);
  timeunit 1ns;
  timeprecision 1ns;
  // Must follow the delays the bench programs; target and margin stay at reset
  localparam int START_DLY = 5;
  localparam int RAMP_T    = 5;
  localparam int OV_LIM    = 138;
  logic [7:0] en_cnt_r;
  logic [7:0] hi_cnt_r;
  logic [1:0] age_r;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_cnt_r <= 8'h0;
      hi_cnt_r <= 8'h0;
      age_r    <= 2'h0;
    end
    else
    begin
      en_cnt_r <= i_enable ? en_cnt_r + 8'(en_cnt_r != 8'hff) : 8'h0;
      hi_cnt_r <= o_high_drive_en ? hi_cnt_r + 8'(hi_cnt_r != 8'hff) : 8'h0;
      age_r    <= age_r + 2'(age_r != 2'h3);
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // ********************
  // Assertions
  // ********************
  chk_ov_pg_drop: assert property (
    i_output_sense_input > OV_LIM |-> ##[1:2] !o_power_good_output)
    else $error("power good up during overvoltage");
  chk_ov_high_off: assert property (
    o_high_drive_en && i_output_sense_input > OV_LIM |-> ##[1:2] !o_high_drive_en)
    else $error("high side kept on in overvoltage");
  chk_pg_drives: assert property (
    o_power_good_output |-> o_high_drive_en && o_low_drive_en)
    else $error("power good without both drives");
  chk_pair_rise: assert property ($rose(o_high_drive_en) |-> o_low_drive_en)
    else $error("drives not enabled together");
  chk_start_wait: assert property ($rose(o_high_drive_en) |-> en_cnt_r >= START_DLY)
    else $error("drives on before start delay");
  chk_ramp_wait: assert property ($rose(o_power_good_output) |-> hi_cnt_r >= RAMP_T)
    else $error("power good before ramp time");
  chk_ext_no_hold: assert property (
    i_ext_clk_mode && $fell(o_high_drive_en) |-> !o_low_drive_en)
    else $error("low side held with external clock");
  chk_lock_bounds: assert property (
    age_r == 2'h3 && (i_vin < 12'h11d || i_vin >= 12'h640)
    |=> o_input_low_lockout == $past(i_vin < 12'h11d))
    else $error("lockout flag outside threshold range");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0)
    else $error("read data outside read cycle");

  cov_pg_up: cover property ($rose(o_power_good_output));
  cov_low_hold: cover property (o_low_drive_en && !o_high_drive_en);
  cov_lockout: cover property ($rose(o_input_low_lockout));
endmodule

// file: bench/converter_fault_supervisor_tb.sv
bind converter_fault_supervisor converter_fault_supervisor_checker u_chk (
  .i_clk_sys, .i_rst, .i_enable, .i_vin, .i_output_sense_input, .i_ext_clk_mode,
  .i_rd, .o_rdata, .o_high_drive_en, .o_low_drive_en, .o_power_good_output,
  .o_input_low_lockout
);

module converter_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        wr;
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;
  localparam row_t ROWS [17] = '{
    '{1'b0, 4'h1, 16'h0, 16'h02bc}, '{1'b0, 4'h2, 16'h0, 16'h0078},
    '{1'b0, 4'h3, 16'h0, 16'h000f}, '{1'b0, 4'h4, 16'h0, 16'h007d},
    '{1'b0, 4'h5, 16'h0, 16'h0030}, '{1'b0, 4'h8, 16'h0, 16'h0030},
    '{1'b0, 4'h9, 16'h0, 16'h0fa0}, '{1'b0, 4'ha, 16'h0, 16'h07d0},
    '{1'b0, 4'hb, 16'h0, 16'h07d0}, '{1'b0, 4'he, 16'h0, 16'h0000},
    '{1'b1, 4'h1, 16'h0100, 16'h011d}, '{1'b1, 4'h1, 16'h0700, 16'h0640},
    '{1'b1, 4'h1, 16'h0320, 16'h0320}, '{1'b1, 4'he, 16'h1234, 16'h0000},
    '{1'b1, 4'h9, 16'h0008, 16'h0008}, '{1'b1, 4'ha, 16'h0005, 16'h0005},
    '{1'b1, 4'hb, 16'h0005, 16'h0005}
  };
  // Per response mode: on soon after the fault, on later, back after clearing
  localparam logic [4:0] EA = 5'b00110;
  localparam logic [4:0] EB = 5'b00010;
  localparam logic [4:0] EC = 5'b11011;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_enable = 1'b0;
  logic [2:0]  i_strap_code = 3'h3;
  logic [11:0] i_vin = 12'h640;
  logic [11:0] i_output_sense_input;
  logic [7:0]  i_die_temp = 8'h19;
  logic        i_oc_fault = 1'b0;
  logic        i_ext_clk_mode = 1'b0;
  logic        i_share_group = 1'b0;
  logic        i_track_en = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic        o_high_drive_en;
  logic        o_low_drive_en;
  logic        o_power_good_output;
  logic [11:0] o_work_target;
  logic        o_input_low_lockout;
  logic [11:0] prebias = 12'h03c;
  logic        surge = 1'b0;
  logic [15:0] rv;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;

  converter_fault_supervisor u_dut (
    .i_clk_sys, .i_rst, .i_enable, .i_strap_code, .i_vin, .i_output_sense_input,
    .i_die_temp, .i_oc_fault, .i_ext_clk_mode, .i_share_group, .i_track_en,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_high_drive_en, .o_low_drive_en,
    .o_power_good_output, .o_work_target, .o_input_low_lockout
  );
  power_stage_model u_stage (
    .i_clk_sys,
    .i_high_drive_en (o_high_drive_en),
    .i_low_drive_en  (o_low_drive_en),
    .i_work_target   (o_work_target),
    .i_prebias       (prebias),
    .i_surge         (surge),
    .o_vout          (i_output_sense_input)
  );

  // ********************
  // Helpers
  // ********************
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check16(input string name, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk_sys);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask
  // Data is taken one edge after the strobe edge, before that edge's updates land
  task automatic rd_reg(input logic [3:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    tick(1);
    rv = o_rdata;
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? o_high_drive_en : o_power_good_output;
  endfunction
  task automatic wait_on(input int w, input logic v, input int bound);
    n = 0;
    while (pick(w) !== v && n < bound)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic restart(input int w);
    i_enable <= 1'b0;
    tick(2);
    i_enable <= 1'b1;
    wait_on(w, 1'b1, 60);
  endtask
  task automatic set_fault(input int k, input logic f);
    case (k)
      0: i_vin <= f ? 12'h064 : 12'h640;
      1: i_oc_fault <= f;
      default: i_die_temp <= f ? 8'h82 : 8'h64;
    endcase
  endtask

  initial
    forever #25 i_clk_sys = ~i_clk_sys;

  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ********************
  // Sequence
  // ********************
  initial
  begin
    tick(20);
    check16("reset outputs", 16'h0, {13'h0, o_high_drive_en, o_low_drive_en, o_power_good_output});
    i_rst <= 1'b0;
    tick(2);
    foreach (ROWS[r])
    begin
      if (ROWS[r].wr)
        wr_reg(ROWS[r].a, ROWS[r].d);
      rd_reg(ROWS[r].a);
      check16("register", ROWS[r].e, rv);
    end
    i_enable <= 1'b1;
    wait_on(0, 1'b1, 30);
    check16("start delay", 16'h1, {15'h0, n inside {[7:9]}});
    check16("low pre-bias start", 16'h003c, {4'h0, o_work_target});
    wait_on(1, 1'b1, 30);
    check16("ramp time", 16'h1, {15'h0, n inside {[5:7]}});
    check16("ramp end", 16'h0078, {4'h0, o_work_target});
    surge <= 1'b1;
    tick(4);
    check16("ov shutdown", 16'h0, {14'h0, o_high_drive_en, o_power_good_output});
    surge <= 1'b0;
    wait_on(1, 1'b1, 60);
    check16("ov recover", 16'h1, {15'h0, o_power_good_output});
    prebias <= 12'h082;
    restart(0);
    check16("high pre-bias start", 16'h0082, {4'h0, o_work_target});
    wait_on(1, 1'b1, 30);
    check16("high pre-bias pg", 16'h1, {15'h0, n inside {[5:7]}});
    tick(12);
    check16("ramp down", 16'h0078, {4'h0, o_work_target});
    prebias <= 12'h096;
    restart(0);
    rd_reg(4'hc);
    check16("ov pre-bias", 16'h3, {13'h0, o_high_drive_en, rv[5:4]});
    prebias <= 12'h0;
    wait_on(1, 1'b1, 60);
    check16("ov pre-bias clear", 16'h1, {15'h0, o_power_good_output});
    {i_share_group, i_track_en} <= 2'h3;
    prebias <= 12'h03c;
    restart(0);
    check16("no pre-bias", 16'h0, {4'h0, o_work_target});
    {i_share_group, i_track_en} <= 2'h0;
    wr_reg(4'h8, 16'h0035);
    for (int x = 0; x < 2; x++)
    begin
      i_ext_clk_mode <= x[0];
      restart(1);
      surge <= 1'b1;
      tick(4);
      check16("ov hold", {15'h0, !x[0]}, {14'h0, o_high_drive_en, o_low_drive_en});
      surge <= 1'b0;
    end
    i_ext_clk_mode <= 1'b0;
    wr_reg(4'h8, 16'h0030);
    // Fault kinds: lockout, overcurrent, thermal; response codes 0 to 4 each
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 5; m++)
      begin
        wr_reg(4'h5 + 4'(k), {12'h003, 1'b0, 3'(m)});
        restart(1);
        set_fault(k, 1'b1);
        tick(4);
        check16("fault early", {15'h0, EA[m]}, {15'h0, o_high_drive_en});
        if (k == 0)
          check16("lockout flag", 16'h1, {15'h0, o_input_low_lockout});
        tick(12);
        check16("fault late", {15'h0, EB[m]}, {15'h0, o_high_drive_en});
        if (k == 2 && m > 2)
        begin
          i_die_temp <= 8'h73;
          tick(30);
          check16("thermal margin", 16'h0, {15'h0, o_high_drive_en});
        end
        set_fault(k, 1'b0);
        wait_on(0, 1'b1, 60);
        check16("fault clear", {15'h0, EC[m]}, {15'h0, o_high_drive_en});
      end
    wr_reg(4'h6, 16'h0013);
    restart(1);
    for (int t = 0; t < 2; t++)
    begin
      i_oc_fault <= 1'b1;
      tick(12);
      i_oc_fault <= 1'b0;
      wait_on(0, 1'b1, 60);
    end
    rd_reg(4'hc);
    check16("retries spent", 16'h1, {14'h0, o_high_drive_en, rv[7]});
    wr_reg(4'h0, 16'h0001);
    wait_on(0, 1'b1, 60);
    check16("restart command", 16'h1, {15'h0, o_high_drive_en});
    end_of_test();
  end
endmodule

// file: bench/power_stage_model.sv
module power_stage_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_high_drive_en,
  input  wire logic        i_low_drive_en,
  input  wire logic [11:0] i_work_target,
  input  wire logic [11:0] i_prebias,
  input  wire logic        i_surge,
  output logic      [11:0] o_vout
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven output sits at the external pre-bias; low side alone pulls it down
  always @(posedge i_clk_sys)
  begin
    if (i_high_drive_en && i_low_drive_en)
      o_vout <= i_work_target + (i_surge ? 12'h028 : 12'h0);
    else if (i_low_drive_en)
      o_vout <= 12'h0;
    else
      o_vout <= i_prebias;
  end
endmodule

// file: hdl/converter_fault_supervisor.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "converter_fault_supervisor_map.svh"

module converter_fault_supervisor (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_enable,
  input  wire logic [2:0]  i_strap_code,
  input  wire logic [11:0] i_vin,
  input  wire logic [11:0] i_output_sense_input,
  input  wire logic [7:0]  i_die_temp,
  input  wire logic        i_oc_fault,
  input  wire logic        i_ext_clk_mode,
  input  wire logic        i_share_group,
  input  wire logic        i_track_en,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  output logic             o_high_drive_en,
  output logic             o_low_drive_en,
  output logic             o_power_good_output,
  output logic      [11:0] o_work_target,
  output logic             o_input_low_lockout
);
  import converter_fault_supervisor_pkg::*;

  st_t s_r;
  st_t s_nxt;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [11:0] strap_thr(input logic [2:0] code);
    unique case (code)
      3'h0:    strap_thr = 12'h1c2;
      3'h1:    strap_thr = 12'h1f4;
      3'h2:    strap_thr = 12'h258;
      3'h3:    strap_thr = 12'h2bc;
      3'h4:    strap_thr = 12'h320;
      3'h5:    strap_thr = 12'h384;
      3'h6:    strap_thr = 12'h3e8;
      default: strap_thr = 12'h438;
    endcase
  endfunction

  function automatic logic [11:0] clamp_thr(input logic [11:0] v);
    if (v < `LOCK_MIN)
      clamp_thr = `LOCK_MIN;
    else if (v > `LOCK_MAX)
      clamp_thr = `LOCK_MAX;
    else
      clamp_thr = v;
  endfunction

  function automatic logic [12:0] ov_limit(input logic [11:0] t, input logic [7:0] pct);
    logic [19:0] prod;
    prod = t * pct;
    ov_limit = {1'b0, t} + 13'(prod / 20'd100);
  endfunction

  // Illegal choices for a given fault fall back to the default shutdown
  function automatic resp_mode_t eff_mode(input fault_t f, input resp_mode_t m,
                                          input logic ext_clk);
    eff_mode = m;
    unique case (f)
      F_UV:
        if (!(m inside {RESP_CONTINUE, RESP_DELAY_OFF, RESP_RETRY_N}))
          eff_mode = RESP_IMMEDIATE;
      F_OV:
        if (!(m inside {RESP_RETRY_N, RESP_LOW_HOLD}) || (m == RESP_LOW_HOLD && ext_clk))
          eff_mode = RESP_IMMEDIATE;
      default:
        if (m inside {RESP_LOW_HOLD, RESP_RSVD6, RESP_RSVD7})
          eff_mode = RESP_IMMEDIATE;
    endcase
  endfunction

  // Linear point between two levels; length is fixed whatever the start
  function automatic logic [11:0] ramp_point(input logic [11:0] a, input logic [11:0] b,
                                             input logic [15:0] n, input logic [15:0] len);
    logic [27:0] step;
    step = 28'h0;
    if (len == 16'h0000)
      ramp_point = b;
    else if (b >= a)
    begin
      step = (b - a) * n;
      ramp_point = a + 12'(step / {12'h000, len});
    end
    else
    begin
      step = (a - b) * n;
      ramp_point = a - 12'(step / {12'h000, len});
    end
  endfunction

  // ****************************************************************
  // Fault conditions
  // ****************************************************************
  logic [3:0]  cond;
  logic [3:0]  clear_ok;
  logic [12:0] ov_lim;
  logic [7:0]  ot_release;
  logic        prebias_on;
  logic        restart_cmd;

  always_comb
  begin
    ov_lim           = ov_limit(s_r.target, s_r.ov_pct);
    ot_release       = (s_r.temp_lim > `OT_HYST) ? s_r.temp_lim - `OT_HYST : 8'h00;
    cond[F_UV]       = i_vin < s_r.lock_thr;
    cond[F_OV]       = {1'b0, i_output_sense_input} > ov_lim;
    cond[F_OC]       = i_oc_fault;
    cond[F_OT]       = i_die_temp > s_r.temp_lim;
    clear_ok         = ~cond;
    clear_ok[F_OT]   = i_die_temp < ot_release;
    prebias_on       = !(i_share_group && i_track_en);
    restart_cmd      = (i_wr && i_addr == `ADDR_CTRL && i_wdata[`CTRL_RESTART_BIT])
                       || (i_enable && !s_r.enable_d);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic        trip;
    logic        any_delay;
    fault_t      tf;
    resp_mode_t  m;
    resp_mode_t  cm;
    s_nxt    = s_r;
    trip     = 1'b0;
    any_delay = 1'b0;
    tf       = F_UV;
    m        = RESP_IMMEDIATE;
    cm       = eff_mode(s_r.cause, s_r.mode[s_r.cause], i_ext_clk_mode);
    s_nxt.enable_d = i_enable;
    s_nxt.rdata    = 16'h0000;

    // Strap caught once after reset release unless software already wrote one
    if (!s_r.strap_done)
    begin
      s_nxt.strap_done = 1'b1;
      if (!s_r.thr_override)
        s_nxt.lock_thr = strap_thr(i_strap_code);
    end

    // Register writes
    if (i_wr)
    begin
      unique case (i_addr)
        `ADDR_LOCK_THR:
        begin
          s_nxt.lock_thr     = clamp_thr(i_wdata[11:0]);
          s_nxt.thr_override = 1'b1;
        end
        `ADDR_TARGET:    s_nxt.target    = i_wdata[11:0];
        `ADDR_OV_PCT:    s_nxt.ov_pct    = i_wdata[7:0];
        `ADDR_TEMP_LIM:  s_nxt.temp_lim  = i_wdata[7:0];
        `ADDR_RETRY_DLY: s_nxt.retry_dly = i_wdata;
        `ADDR_RAMP_TIME: s_nxt.ramp_time = i_wdata;
        `ADDR_START_DLY: s_nxt.start_dly = i_wdata;
        default:
          if (i_addr >= `ADDR_RESP_BASE && i_addr < `ADDR_RETRY_DLY)
          begin
            s_nxt.mode[2'(i_addr - `ADDR_RESP_BASE)]      = resp_mode_t'(i_wdata[2:0]);
            s_nxt.retry_lim[2'(i_addr - `ADDR_RESP_BASE)] = i_wdata[7:4];
          end
      endcase
    end

    // Register reads, data valid in the next cycle only
    if (i_rd)
    begin
      unique case (i_addr)
        `ADDR_LOCK_THR:  s_nxt.rdata = {4'h0, s_r.lock_thr};
        `ADDR_TARGET:    s_nxt.rdata = {4'h0, s_r.target};
        `ADDR_OV_PCT:    s_nxt.rdata = {8'h00, s_r.ov_pct};
        `ADDR_TEMP_LIM:  s_nxt.rdata = {8'h00, s_r.temp_lim};
        `ADDR_RETRY_DLY: s_nxt.rdata = s_r.retry_dly;
        `ADDR_RAMP_TIME: s_nxt.rdata = s_r.ramp_time;
        `ADDR_START_DLY: s_nxt.rdata = s_r.start_dly;
        `ADDR_STATUS:    s_nxt.rdata = {5'h00, s_r.state, s_r.state == ST_LATCHED,
                                        s_r.pg, s_r.cause, cond};
        `ADDR_WORK:      s_nxt.rdata = {4'h0, s_r.work};
        default:
          if (i_addr >= `ADDR_RESP_BASE && i_addr < `ADDR_RETRY_DLY)
            s_nxt.rdata = {8'h00, s_r.retry_lim[2'(i_addr - `ADDR_RESP_BASE)], 1'b0,
                           s_r.mode[2'(i_addr - `ADDR_RESP_BASE)]};
      endcase
    end

    // Fault trip evaluation in every state, whether or not the drivers are on
    for (int i = 0; i < 4; i++)
    begin
      m = eff_mode(fault_t'(i), s_r.mode[i], i_ext_clk_mode);
      if (cond[i] && m == RESP_DELAY_OFF)
        any_delay = 1'b1;
      if (cond[i] && m != RESP_CONTINUE
          && (m != RESP_DELAY_OFF || s_r.grace >= s_r.retry_dly))
      begin
        trip = 1'b1;
        tf   = fault_t'(i);
      end
    end
    s_nxt.grace = (any_delay && s_r.grace != 16'hffff) ? s_r.grace + 16'h0001 : 16'h0000;

    if (restart_cmd)
      s_nxt.retry_cnt = '0;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    unique case (s_r.state)
      ST_OFF:
        if (i_enable && s_r.strap_done && !(cond[F_UV] && s_r.mode[F_UV] != RESP_CONTINUE))
        begin
          s_nxt.state = ST_DELAY;
          s_nxt.cnt   = 16'h0000;
        end
      ST_DELAY:
        if (s_r.cnt >= s_r.start_dly)
        begin
          s_nxt.cnt       = 16'h0000;
          s_nxt.down_pend = 1'b0;
          s_nxt.ramp_to   = s_r.target;
          s_nxt.ramp_from = 12'h000;
          if (prebias_on && {1'b0, i_output_sense_input} > ov_lim)
          begin
            s_nxt.state = ST_OFF;   // Overwritten by the trip path below
            trip        = 1'b1;
            tf          = F_OV;
          end
          else
          begin
            s_nxt.state = ST_RAMP;
            s_nxt.hi    = 1'b1;
            s_nxt.lo    = 1'b1;
            if (prebias_on)
            begin
              s_nxt.ramp_from = i_output_sense_input;
              if (i_output_sense_input > s_r.target)
              begin
                s_nxt.ramp_to   = i_output_sense_input;
                s_nxt.down_pend = 1'b1;
              end
            end
            s_nxt.work = s_nxt.ramp_from;
          end
        end
        else
          s_nxt.cnt = s_r.cnt + 16'h0001;
      ST_RAMP:
      begin
        s_nxt.work = ramp_point(s_r.ramp_from, s_r.ramp_to, s_r.cnt, s_r.ramp_time);
        if (s_r.cnt >= s_r.ramp_time)
        begin
          s_nxt.cnt = 16'h0000;
          s_nxt.pg  = 1'b1;
          if (s_r.down_pend)
          begin
            s_nxt.down_pend = 1'b0;
            s_nxt.ramp_from = s_r.ramp_to;
            s_nxt.ramp_to   = s_r.target;
          end
          else
            s_nxt.state = ST_RUN;
        end
        else
          s_nxt.cnt = s_r.cnt + 16'h0001;
      end
      ST_RUN:
      begin
        s_nxt.work = s_r.target;
        s_nxt.pg   = 1'b1;
      end
      ST_WAIT, ST_LOW_HOLD:
        if (cm == RESP_IMMEDIATE)
        begin
          if (clear_ok[s_r.cause])
          begin
            s_nxt.state = ST_OFF;
            s_nxt.lo    = 1'b0;
          end
        end
        else if (s_r.cnt >= s_r.retry_dly)
        begin
          s_nxt.cnt = 16'h0000;
          if (clear_ok[s_r.cause])
          begin
            s_nxt.state = ST_OFF;
            s_nxt.lo    = 1'b0;   // Low side released at the restart, or earlier on disable
            s_nxt.retry_cnt[s_r.cause] = s_r.retry_cnt[s_r.cause] + 4'h1;
          end
        end
        else
          s_nxt.cnt = s_r.cnt + 16'h0001;
      ST_LATCHED:
        if (restart_cmd)
          s_nxt.state = ST_OFF;
      default:
        s_nxt.state = ST_OFF;
    endcase

    // Trip takes effect from delay, ramp and run
    if (trip && s_r.state inside {ST_DELAY, ST_RAMP, ST_RUN})
    begin
      m           = eff_mode(tf, s_r.mode[tf], i_ext_clk_mode);
      s_nxt.cause = tf;
      s_nxt.cnt   = 16'h0000;
      s_nxt.pg    = 1'b0;
      s_nxt.hi    = 1'b0;
      s_nxt.lo    = 1'b0;
      s_nxt.work  = 12'h000;
      if (m == RESP_DELAY_OFF)
        s_nxt.state = ST_LATCHED;
      else if (m == RESP_RETRY_N && s_r.retry_cnt[tf] >= s_r.retry_lim[tf])
        s_nxt.state = ST_LATCHED;
      else if (m == RESP_LOW_HOLD)
      begin
        s_nxt.state = ST_LOW_HOLD;
        s_nxt.lo    = 1'b1;
      end
      else
        s_nxt.state = ST_WAIT;
    end

    // Overvoltage always drops power good
    if (cond[F_OV])
      s_nxt.pg = 1'b0;

    // Disable overrides everything but a latched fault
    if (!i_enable && s_r.state != ST_LATCHED)
    begin
      s_nxt.state     = ST_OFF;
      s_nxt.hi        = 1'b0;
      s_nxt.lo        = 1'b0;
      s_nxt.pg        = 1'b0;
      s_nxt.work      = 12'h000;
      s_nxt.down_pend = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r              <= '0;
      s_r.state        <= ST_OFF;
      s_r.lock_thr     <= `RST_LOCK_THR;
      s_r.target       <= `RST_TARGET;
      s_r.ov_pct       <= `RST_OV_PCT;
      s_r.temp_lim     <= `RST_TEMP_LIM;
      s_r.mode         <= '{4{RESP_IMMEDIATE}};
      s_r.retry_lim    <= {4{`RST_RETRY_LIM}};
      s_r.retry_dly    <= `RETRY_CYC;
      s_r.ramp_time    <= `RAMP_CYC;
      s_r.start_dly    <= `START_DLY_CYC;
    end
    else
      s_r <= s_nxt;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_input_low_lockout <= 1'b0;
    else
      o_input_low_lockout <= cond[F_UV];
  end

  assign o_rdata             = s_r.rdata;
  assign o_high_drive_en     = s_r.hi;
  assign o_low_drive_en      = s_r.lo;
  assign o_power_good_output = s_r.pg;
  assign o_work_target       = s_r.work;

endmodule

// file: hdl/converter_fault_supervisor_map.svh
// Overview of operation
// - Strap code picks the lockout threshold between 4.5 V and 10.8 V.
// - Software may write a lockout threshold of 2.85 V to 16 V; it overrides the strap.
// - Lockout fault response: keep running, delayed latch-off, or shutdown with retries.
// - Default lockout response: shut down at once, restart when the fault clears.
// - Overvoltage above target plus 15 percent drops power good.
// - Overvoltage response: shutdown with retries, or high side off with low side held on.
// - Default overvoltage response: shut down at once, restart when it clears.
// - With an external clock the low-side-hold overvoltage response is refused.
// - Output is sampled for pre-bias before the ramp starts, unless pre-bias handling is off.
// - Pre-bias below target: start from pre-bias, both drivers on, ramp up.
// - Ramp from pre-bias ends exactly one ramp time after the start delay.
// - Pre-bias above target: hold it, power good after ramp time, then ramp down.
// - Pre-bias above the overvoltage limit: no start, overvoltage fault raised.
// - Pre-bias handling is off in a current-sharing group with tracking on.
// - Overcurrent: endless retries, counted retries, delayed off, continue, or immediate.
// - Default overcurrent response: shut down at once, restart when it clears.
// - Die temperature above a limit, 125 C by default, is a thermal fault.
// - Thermal fault offers the same five responses as overcurrent.
// - Thermal retry waits the delay and restarts only 15 C below the limit.
// - Default thermal response: shut down at once, restart when it clears.
`ifndef CONVERTER_FAULT_SUPERVISOR_MAP_SVH
`define CONVERTER_FAULT_SUPERVISOR_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_CTRL        4'h0
`define ADDR_LOCK_THR    4'h1
`define ADDR_TARGET      4'h2
`define ADDR_OV_PCT      4'h3
`define ADDR_TEMP_LIM    4'h4
`define ADDR_RESP_BASE   4'h5
`define ADDR_RETRY_DLY   4'h9
`define ADDR_RAMP_TIME   4'ha
`define ADDR_START_DLY   4'hb
`define ADDR_STATUS      4'hc
`define ADDR_WORK        4'hd

// ****************************************************************
// Fields and limits (voltages in 10 mV steps)
// ****************************************************************
`define CTRL_RESTART_BIT 0
`define LOCK_MIN         12'h11d
`define LOCK_MAX         12'h640
`define OT_HYST          8'h0f
`define RST_LOCK_THR     12'h1c2
`define RST_TARGET       12'h078
`define RST_OV_PCT       8'h0f
`define RST_TEMP_LIM     8'h7d
`define RST_RETRY_LIM    4'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ          20
`define START_DLY_US     100
`define RAMP_US          100
`define RETRY_US         200
`define START_DLY_CYC    16'((`START_DLY_US) * (`CLK_MHZ))
`define RAMP_CYC         16'((`RAMP_US) * (`CLK_MHZ))
`define RETRY_CYC        16'((`RETRY_US) * (`CLK_MHZ))

`endif

// file: hdl/converter_fault_supervisor_pkg.sv
package converter_fault_supervisor_pkg;

  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_WAIT, ST_LOW_HOLD, ST_LATCHED
  } state_t;

  // Raw response codes as written by software
  typedef enum logic [2:0] {
    RESP_IMMEDIATE, RESP_CONTINUE, RESP_DELAY_OFF, RESP_RETRY_N,
    RESP_RETRY_INF, RESP_LOW_HOLD, RESP_RSVD6, RESP_RSVD7
  } resp_mode_t;

  // Fault index; higher index wins when several trip together
  typedef enum logic [1:0] {
    F_UV, F_OC, F_OT, F_OV
  } fault_t;

  typedef struct packed {
    state_t                 state;
    logic                   strap_done;
    logic                   thr_override;
    logic [11:0]            lock_thr;
    logic [11:0]            target;
    logic [7:0]             ov_pct;
    logic [7:0]             temp_lim;
    resp_mode_t [3:0]       mode;
    logic [3:0][3:0]        retry_lim;
    logic [3:0][3:0]        retry_cnt;
    logic [15:0]            retry_dly;
    logic [15:0]            ramp_time;
    logic [15:0]            start_dly;
    logic [15:0]            cnt;
    logic [15:0]            grace;
    fault_t                 cause;
    logic [11:0]            ramp_from;
    logic [11:0]            ramp_to;
    logic [11:0]            work;
    logic                   down_pend;
    logic                   enable_d;
    logic                   pg;
    logic                   hi;
    logic                   lo;
    logic [15:0]            rdata;
  } st_t;

endpackage
